//--- pbl_pkg.sv
/*
  Shared constants and carriers for the phase build-out and loop monitor block.
  Assumes a 250 MHz system clock and reference clocks of unknown phase.
*/
`default_nettype none
package pbl_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_FREQ_LOW    = 8'h07;
  localparam logic [7:0] ADDR_FREQ_MID    = 8'h0c;
  localparam logic [7:0] ADDR_FREQ_HIGH   = 8'h0d;
  localparam logic [7:0] ADDR_MON_CHAN    = 8'h4b;
  localparam logic [7:0] ADDR_MON_READ    = 8'h4c;
  localparam logic [7:0] ADDR_AUX_PD_SEL  = 8'h65;
  localparam logic [7:0] ADDR_TRIM        = 8'h72;
  localparam logic [7:0] ADDR_PHASE_LOW   = 8'h77;
  localparam logic [7:0] ADDR_PHASE_HIGH  = 8'h78;
  // Field positions and reset values
  localparam int         REPORT_SEL_BIT   = 4;
  localparam int         AUX_FROM_MAIN_BIT = 7;
  localparam logic [7:0] MON_CHAN_RESET   = 8'h00;
  localparam logic [7:0] AUX_PD_RESET     = 8'h00;
  localparam logic [7:0] TRIM_RESET       = 8'h00;
  // Trim: 0.101 ns steps, limited to 1.4 ns, so 13 whole steps
  localparam int         TRIM_STEP_PS     = 101;
  localparam int         TRIM_LIMIT_PS    = 1400;
  localparam logic signed [7:0] TRIM_MAX  = 8'(TRIM_LIMIT_PS / TRIM_STEP_PS);
  // ==========================================================
  // Timing
  localparam int         CLK_MHZ          = 250;
  localparam int         WINDOW_MS        = 100;
  localparam int         WINDOW_CYCLES    = WINDOW_MS * 1000 * CLK_MHZ;
  localparam int         HOLD_US          = 10;
  localparam int         HOLD_CYCLES      = HOLD_US * CLK_MHZ;
  localparam int         ACT_NS           = 1000;
  localparam int         ACT_CYCLES       = ACT_NS * CLK_MHZ / 1000;
  localparam int         LONG_US          = 2500;
  localparam int         LONG_CYCLES      = LONG_US * CLK_MHZ;
  localparam int         SLEW_BASE_CYCLES = 256;
  // Phase figures in 1 ns units
  localparam logic [16:0] PHASE_START_NS  = 17'h0009c;
  localparam logic [11:0] THR_MIN_NS      = 12'h3e8;
  localparam logic [11:0] THR_MAX_NS      = 12'hdac;
  // Acceptance ranges: loop range in 0.08 ppm, monitor in 3.8 ppm steps
  localparam logic [9:0] LOOP_RANGE_RESET = 10'h073;
  localparam logic [9:0] LOOP_RANGE_MAX   = 10'h3e8;
  localparam logic [4:0] MON_LIMIT_MAX    = 5'h10;
  localparam int         MON_TO_RANGE_NUM = 95;
  localparam int         MON_TO_RANGE_DEN = 2;
  localparam int         MULTI_HITS       = 2;
  // Report filter shift for a corner near 152 Hz at 250 MHz
  localparam int         FILT_SHIFT       = 18;
  // ==========================================================
  // Build-out control bits from the host
  typedef struct packed {
    logic        enable;
    logic        freeze;
    logic        auto_hi;
    logic        auto_lo;
    logic [11:0] threshold_ns;
    logic [3:0]  bandwidth;
  } pbl_ctrl_t;
  // Correction handed to the loop
  typedef struct packed {
    logic signed [16:0] offset_ns;
    logic signed [7:0]  trim_steps;
    logic               holdover;
    logic               fine_adjust_en;
  } pbl_corr_t;
endpackage
`default_nettype wire

//--- pbl_top.sv
/*
  Phase build-out, reference monitors and loop reports, all in one module.
  Assumes a phase detector result in 1 ns units on clk_sys, loop integral and
  phase values from both loops, and one free running clock port per reference.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Phase error above 156 ns starts a 0.1 second watch interval.
// - Jump beyond threshold inside interval fires build-out when both auto bits set.
// - Build-out holds over, measures reference phase, then injects matching offset.
// - Build-out can be enabled, disabled or frozen; enabled after reset.
// - Frozen build-out ignores further events and keeps accumulated offset.
// - Disabling while locked slews offset back to zero at bandwidth rate.
// - Enabling build-out while locked fires a build-out event.
// - Systematic trim in 0.101 ns steps, clamped to plus or minus 1.4 ns.
// - Monitor activity and frequency; long or repeated outages force reselection.
// - Failed reference leaves selection until its quality is good again.
// - Reject references outside hold-in range or with excessive jitter.
// - Loop acceptance range defaults to 9.2 ppm, programmable 0 to 80 ppm.
// - Monitors take limit up to 60.8 ppm, 3.8 ppm steps, channel-selected read.
// - Loop frequency report is 19-bit signed integral path value.
// - One bit picks main or auxiliary loop for both reports.
// - Phase report is detector difference filtered near 152 Hz.
// - A bit routes auxiliary detector input to the main loop reference.
// - Without auto bits a jump only raises a flag for the host.
// - Fine output phase adjust works only when build-out enable and auto_lo are both off.
module pbl_top #(
  parameter int N_REF       = 14,
  parameter int WIN_CYCLES  = pbl_pkg::WINDOW_CYCLES,
  parameter int GATE_CYCLES = 789474,
  parameter int NOM_COUNT   = 263158,
  parameter int LONG_LIMIT  = pbl_pkg::LONG_CYCLES
) (
  // System clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Reference clocks
  input  wire logic [N_REF-1:0]    clk_ref,
  input  wire logic [N_REF-1:0]    ref_jitter_bad,
  // Microprocessor port
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // Build-out control and loop state
  input  wire pbl_pkg::pbl_ctrl_t  ctrl,
  input  wire logic                loop_locked,
  input  wire logic                ref_switch,
  input  wire logic                host_pbo_request,
  input  wire logic signed [16:0]  pd_phase_ns,
  input  wire logic [9:0]          loop_range,
  input  wire logic [4:0]          mon_limit,
  // Loop values for reporting and detector routing
  input  wire logic signed [18:0]  main_integral,
  input  wire logic signed [18:0]  aux_integral,
  input  wire logic signed [15:0]  main_pd,
  input  wire logic signed [15:0]  aux_pd,
  input  wire logic [3:0]          main_ref_sel,
  input  wire logic [3:0]          aux_ref_sel,
  input  wire logic [3:0]          selected_ref,
  // Results
  output pbl_pkg::pbl_corr_t       corr,
  output logic                     phase_jump_flag,
  output logic                     pbo_event,
  output logic [3:0]               aux_pd_src,
  output logic [N_REF-1:0]         ref_usable,
  output logic                     force_reselect,
  output logic [9:0]               loop_range_eff
);

  typedef enum {ST_IDLE, ST_WATCH, ST_HOLD} pbl_state_t;

  // ==========================================================
  // Helpers
  function automatic logic [19:0] pbl_gray2bin(input logic [19:0] g);
    logic [19:0] b;
    b = '0;
    b[19] = g[19];
    for (int i = 18; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [16:0] pbl_abs17(input logic signed [16:0] v);
    return v[16] ? 17'(-v) : 17'(v);
  endfunction

  // ==========================================================
  // Register file
  logic [7:0]        mon_chan;
  logic [7:0]        aux_pd_cfg;
  logic signed [7:0] trim;
  logic signed [7:0] next_trim;
  logic [7:0]        mon_reading [N_REF];
  logic signed [18:0] freq_rep;
  logic signed [15:0] phase_rep;

  // Trim write clamped to the allowed span
  always_comb begin
    next_trim = $signed(reg_wdata);
    if ($signed(reg_wdata) > pbl_pkg::TRIM_MAX) begin
      next_trim = pbl_pkg::TRIM_MAX;
    end else if ($signed(reg_wdata) < -pbl_pkg::TRIM_MAX) begin
      next_trim = -pbl_pkg::TRIM_MAX;
    end
  end

  // Writable registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mon_chan   <= pbl_pkg::MON_CHAN_RESET;
      aux_pd_cfg <= pbl_pkg::AUX_PD_RESET;
      trim       <= pbl_pkg::TRIM_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        pbl_pkg::ADDR_MON_CHAN:   mon_chan   <= reg_wdata;
        pbl_pkg::ADDR_AUX_PD_SEL: aux_pd_cfg <= reg_wdata;
        pbl_pkg::ADDR_TRIM:       trim       <= next_trim;
        default:                  ;
      endcase
    end
  end

  // Read path, unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          pbl_pkg::ADDR_FREQ_LOW:   reg_rdata <= freq_rep[7:0];
          pbl_pkg::ADDR_FREQ_MID:   reg_rdata <= freq_rep[15:8];
          pbl_pkg::ADDR_FREQ_HIGH:  reg_rdata <= {{5{freq_rep[18]}}, freq_rep[18:16]};
          pbl_pkg::ADDR_MON_CHAN:   reg_rdata <= mon_chan;
          pbl_pkg::ADDR_MON_READ:   reg_rdata <= (32'(mon_chan[3:0]) < N_REF) ?
                                                 mon_reading[mon_chan[3:0]] : 8'h00;
          pbl_pkg::ADDR_AUX_PD_SEL: reg_rdata <= aux_pd_cfg;
          pbl_pkg::ADDR_TRIM:       reg_rdata <= trim;
          pbl_pkg::ADDR_PHASE_LOW:  reg_rdata <= phase_rep[7:0];
          pbl_pkg::ADDR_PHASE_HIGH: reg_rdata <= phase_rep[15:8];
          default:                  reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Loop reports
  logic signed [33:0] phase_filt;

  // Report source pick and phase low-pass
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      freq_rep   <= '0;
      phase_filt <= '0;
    end else begin
      freq_rep <= mon_chan[pbl_pkg::REPORT_SEL_BIT] ? aux_integral : main_integral;
      phase_filt <= phase_filt + (((34'(mon_chan[pbl_pkg::REPORT_SEL_BIT] ? aux_pd : main_pd)
                    <<< pbl_pkg::FILT_SHIFT) - phase_filt) >>> pbl_pkg::FILT_SHIFT);
    end
  end
  assign phase_rep = phase_filt[pbl_pkg::FILT_SHIFT+15:pbl_pkg::FILT_SHIFT];

  // Auxiliary detector routing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_pd_src <= 4'h0;
    end else begin
      aux_pd_src <= aux_pd_cfg[pbl_pkg::AUX_FROM_MAIN_BIT] ? main_ref_sel : aux_ref_sel;
    end
  end

  // Loop acceptance range
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loop_range_eff <= pbl_pkg::LOOP_RANGE_RESET;
    end else begin
      loop_range_eff <= (loop_range > pbl_pkg::LOOP_RANGE_MAX) ? pbl_pkg::LOOP_RANGE_MAX : loop_range;
    end
  end

  // ==========================================================
  // Phase build-out
  pbl_state_t         state;
  logic [31:0]        win_cnt;
  logic [31:0]        hold_cnt;
  logic [31:0]        slew_cnt;
  logic signed [16:0] offset;
  logic signed [16:0] err;
  logic [16:0]        err_abs;
  logic [11:0]        thr;
  logic               enable_d;
  logic               auto_both;
  logic               active;
  logic               trigger;

  assign err       = pd_phase_ns - offset;
  assign err_abs   = pbl_abs17(err);
  assign auto_both = ctrl.auto_hi & ctrl.auto_lo;
  assign active    = ctrl.enable & ~ctrl.freeze;
  assign trigger   = active & ((ctrl.enable & ~enable_d & loop_locked) | ref_switch | host_pbo_request);

  // Threshold limited to its programmable span
  always_comb begin
    thr = ctrl.threshold_ns;
    if (thr < pbl_pkg::THR_MIN_NS) begin
      thr = pbl_pkg::THR_MIN_NS;
    end else if (thr > pbl_pkg::THR_MAX_NS) begin
      thr = pbl_pkg::THR_MAX_NS;
    end
  end

  // Enable edge detector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_d <= 1'b1;
    end else begin
      enable_d <= ctrl.enable;
    end
  end

  // Watch, hold and inject sequence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      win_cnt         <= '0;
      hold_cnt        <= '0;
      phase_jump_flag <= 1'b0;
      pbo_event       <= 1'b0;
    end else begin
      phase_jump_flag <= 1'b0;
      pbo_event       <= 1'b0;
      case (state)
        ST_IDLE: begin
          win_cnt <= '0;
          if (trigger) begin
            state     <= ST_HOLD;
            hold_cnt  <= '0;
            pbo_event <= 1'b1;
          end else if (active && err_abs > pbl_pkg::PHASE_START_NS) begin
            state <= ST_WATCH;
          end
        end
        ST_WATCH: begin
          win_cnt <= win_cnt + 32'h1;
          if (!active) begin
            state <= ST_IDLE;
          end else if (err_abs > 17'(thr)) begin
            if (auto_both) begin
              state     <= ST_HOLD;
              hold_cnt  <= '0;
              pbo_event <= 1'b1;
            end else begin
              phase_jump_flag <= 1'b1;
              state           <= ST_IDLE;
            end
          end else if (win_cnt >= 32'(WIN_CYCLES - 1)) begin
            state <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          hold_cnt <= hold_cnt + 32'h1;
          if (hold_cnt >= 32'(pbl_pkg::HOLD_CYCLES - 1)) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Accumulated offset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      offset   <= '0;
      slew_cnt <= '0;
    end else if (state == ST_HOLD && hold_cnt >= 32'(pbl_pkg::HOLD_CYCLES - 1)) begin
      offset <= pd_phase_ns;
    end else if (!ctrl.enable && loop_locked && offset != 0) begin
      if (slew_cnt >= (32'(pbl_pkg::SLEW_BASE_CYCLES) << ctrl.bandwidth)) begin
        slew_cnt <= '0;
        offset   <= offset[16] ? offset + 17'sd1 : offset - 17'sd1;
      end else begin
        slew_cnt <= slew_cnt + 32'h1;
      end
    end else begin
      slew_cnt <= '0;
    end
  end

  // Correction outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      corr <= '0;
    end else begin
      corr.offset_ns  <= offset;
      corr.trim_steps <= ctrl.enable ? trim : 8'sh00;
      corr.holdover   <= (state == ST_HOLD);
      corr.fine_adjust_en <= ~ctrl.enable & ~ctrl.auto_lo;
    end
  end

  // ==========================================================
  // Reference monitors
  logic [31:0]      gate_cnt;
  logic             gate_end;
  logic [N_REF-1:0] ref_failed;

  // Shared measurement gate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt <= '0;
      gate_end <= 1'b0;
    end else begin
      gate_end <= (gate_cnt >= 32'(GATE_CYCLES - 1));
      gate_cnt <= (gate_cnt >= 32'(GATE_CYCLES - 1)) ? 32'h0 : gate_cnt + 32'h1;
    end
  end

  for (genvar r = 0; r < N_REF; r++) begin : g_mon
    logic [19:0]        ref_bin;
    logic [19:0]        ref_gray;
    logic [19:0]        gs1;
    logic [19:0]        gs2;
    logic [19:0]        gs3;
    logic [2:0]         jit_s;
    logic [19:0]        seen;
    logic [19:0]        start;
    logic [31:0]        idle_cnt;
    logic [1:0]         hits;
    logic               outage;
    logic               bad_win;
    logic signed [31:0] dev;
    logic [7:0]         rd_now;
    logic [7:0]         rd_abs;

    // Edge counter on the reference clock, gray coded for crossing
    always_ff @(posedge clk_ref[r] or negedge rst_n) begin
      if (!rst_n) begin
        ref_bin  <= '0;
        ref_gray <= '0;
      end else begin
        ref_bin  <= ref_bin + 20'h1;
        ref_gray <= (ref_bin + 20'h1) ^ ((ref_bin + 20'h1) >> 1);
      end
    end

    // Three stage synchronisers
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        gs1   <= '0;
        gs2   <= '0;
        gs3   <= '0;
        jit_s <= '0;
      end else begin
        gs1   <= ref_gray;
        gs2   <= gs1;
        gs3   <= gs2;
        jit_s <= {jit_s[1:0], ref_jitter_bad[r]};
      end
    end

    assign dev = 32'(pbl_gray2bin(seen) - start) - 32'(NOM_COUNT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        seen     <= '0;
        idle_cnt <= '0;
        outage   <= 1'b0;
        hits     <= '0;
      end else begin
        if (gs2 == gs3 && gs3 != seen) begin
          seen     <= gs3;
          idle_cnt <= '0;
          outage   <= 1'b0;
        end else if (idle_cnt < 32'(LONG_LIMIT)) begin
          idle_cnt <= idle_cnt + 32'h1;
        end
        if (idle_cnt == 32'(pbl_pkg::ACT_CYCLES) && !outage) begin
          outage <= 1'b1;
          hits   <= (hits == 2'h3) ? hits : hits + 2'h1;
        end else if (gate_end && !outage) begin
          hits <= '0;
        end
      end
    end

    // Gate end reading and failure verdict
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        start          <= '0;
        mon_reading[r] <= 8'h00;
        ref_failed[r]  <= 1'b1;
        bad_win        <= 1'b0;
      end else begin
        // Gate verdict first, so a bad event in the same cycle wins
        if (gate_end) begin
          start          <= pbl_gray2bin(seen);
          mon_reading[r] <= rd_now;
          bad_win        <= 1'b0;
          ref_failed[r]  <= bad_win || outage ||
                            (rd_abs > 8'(mon_limit > pbl_pkg::MON_LIMIT_MAX ? pbl_pkg::MON_LIMIT_MAX : mon_limit)) ||
                            (32'(rd_abs) * pbl_pkg::MON_TO_RANGE_NUM > 32'(loop_range_eff) * pbl_pkg::MON_TO_RANGE_DEN);
        end
        if (idle_cnt >= 32'(LONG_LIMIT) || 32'(hits) >= pbl_pkg::MULTI_HITS || (jit_s[1] & jit_s[2])) begin
          bad_win       <= 1'b1;
          ref_failed[r] <= 1'b1;
        end
      end
    end
    // Current gate reading clamped to one byte
    assign rd_now = (dev > 32'sd127) ? 8'h7f : (dev < -32'sd127) ? 8'h81 : 8'(dev);
    // monitor magnitude in 3.8 ppm steps
    assign rd_abs = rd_now[7] ? 8'(-rd_now) : rd_now;
  end

  // Usable mask and forced reselection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_usable     <= '0;
      force_reselect <= 1'b0;
    end else begin
      ref_usable     <= ~ref_failed;
      force_reselect <= (32'(selected_ref) < N_REF) ? ref_failed[selected_ref] : 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- pbl_asserts.sv
/*
  Port checker for pbl_top, bound to every instance.
  Assumes one clock domain on clk_sys with rst_n.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Checker
module pbl_asserts (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // Observed ports
  input wire logic               reg_rd,
  input wire logic               reg_rvalid,
  input wire logic               pbo_event,
  input wire logic               phase_jump_flag,
  input wire logic               force_reselect,
  input wire pbl_pkg::pbl_ctrl_t ctrl,
  input wire pbl_pkg::pbl_corr_t corr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
  event_pulse_a: assert property (pbo_event |=> !pbo_event) else $error("event too long");
  event_hold_a: assert property (pbo_event |-> ##[1:2] corr.holdover [*8]) else $error("no holdover");
  frozen_quiet_a: assert property ((!$past(ctrl.enable) || $past(ctrl.freeze)) |-> !pbo_event)
    else $error("event while frozen or off");
  flag_manual_a: assert property (phase_jump_flag |-> !($past(ctrl.auto_hi) && $past(ctrl.auto_lo)))
    else $error("flag in auto mode");
  fine_adj_a: assert property (corr.fine_adjust_en == (!$past(ctrl.enable) && !$past(ctrl.auto_lo)))
    else $error("fine adjust gate wrong");
  trim_clamp_a: assert property (corr.trim_steps <= pbl_pkg::TRIM_MAX && corr.trim_steps >= -pbl_pkg::TRIM_MAX)
    else $error("trim out of range");
  // Main scenarios
  cover property (pbo_event);
  cover property (phase_jump_flag);
  cover property (force_reselect);
endmodule
bind pbl_top pbl_asserts i_chk (.clk_sys, .rst_n, .reg_rd, .reg_rvalid, .pbo_event,
  .phase_jump_flag, .force_reselect, .ctrl, .corr);
`default_nettype wire

//--- pbl_ref_src.sv
/*
  Reference clock sources, one per input, 12 ns period.
  Assumes the bench stops a source by clearing its run bit.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Sources
module pbl_ref_src #(
  parameter int N = 14
) (
  // Control
  input wire logic [N-1:0] run,
  // Clocks
  output logic     [N-1:0] clk_ref
);
  logic tgl = 1'b0;
  // Free phase against the system clock
  initial begin
    #1.3;
    forever #6 tgl = ~tgl;
  end
  assign clk_ref = run & {N{tgl}};
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench for pbl_top with shortened counts.
  Assumes pbl_pkg, pbl_top, pbl_ref_src and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench
module tb_top;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ref_switch = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic reg_rvalid, jflag, pev, frs;
  logic [13:0] run = '1, jit = 0, usable, clk_ref;
  logic signed [16:0] pd = 0;
  logic [9:0] lrange = 10'h073, lre;
  logic [3:0] aux_src;
  logic lock = 1, hreq = 0;
  logic [4:0] mlim = 5'h10;
  logic signed [18:0] mint = 19'h1a3c5, aint = 19'h4a5b6;
  logic signed [15:0] mpd = 0, apd = 0;
  logic [3:0] msel = 4'h3, asel = 4'h9, sref = 4'h0;
  pbl_pkg::pbl_ctrl_t ctrl = '{1'b1, 1'b0, 1'b1, 1'b1, 12'h3e8, 4'h0};
  pbl_pkg::pbl_corr_t corr;
  int errors = 0, cmp_count = 0, cyc = 0, i, n;
  pbl_ref_src i_src (.run(run), .clk_ref(clk_ref));
  pbl_top #(.WIN_CYCLES(200), .GATE_CYCLES(2000), .NOM_COUNT(666), .LONG_LIMIT(500)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_ref(clk_ref), .ref_jitter_bad(jit),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ctrl(ctrl), .loop_locked(lock),
    .ref_switch(ref_switch), .host_pbo_request(hreq), .pd_phase_ns(pd), .loop_range(lrange),
    .mon_limit(mlim), .main_integral(mint), .aux_integral(aint), .main_pd(mpd),
    .aux_pd(apd), .main_ref_sel(msel), .aux_ref_sel(asel), .selected_ref(sref),
    .corr(corr), .phase_jump_flag(jflag), .pbo_event(pev), .aux_pd_src(aux_src),
    .ref_usable(usable), .force_reselect(frs), .loop_range_eff(lre));
  // Clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic tk(input int k = 1);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tk();
    reg_wr = 0;
    tk();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1;
    tk();
    reg_rd = 0;
    chk(reg_rvalid, 1);
    d = reg_rdata;
    tk();
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic wait_ev(input int k);
    for (n = 0; n < k && pev !== 1'b1; n++) tk();
  endtask
  task automatic wait_hold();
    for (n = 0; n < 5 && corr.holdover !== 1'b1; n++) tk();
    chk(corr.holdover, 1);
    for (n = 0; n < 3000 && corr.holdover !== 1'b0; n++) tk();
    tk(2);
  endtask
  // Registers, reports and routing
  task automatic t_reg();
    logic [7:0] d;
    chk(lre, 10'h073);
    rc(8'h72, 8'h00);
    rc(8'h4b, 8'h00);
    wr(8'h72, 8'h7f);
    rc(8'h72, 8'h0d);
    chk(corr.trim_steps, 8'h0d);
    wr(8'h72, 8'hf0);
    rc(8'h72, 8'hf3);
    wr(8'h07, 8'h55);
    rc(8'h07, 8'hc5);
    rc(8'h0c, 8'ha3);
    rc(8'h0d, 8'h01);
    wr(8'h4b, 8'h10);
    rc(8'h07, 8'hb6);
    rc(8'h0c, 8'ha5);
    rc(8'h0d, 8'hfc);
    wr(8'h4b, 8'h00);
    rc(8'h10, 8'h00);
    mpd = 16'h7fff;
    tk(64);
    rc(8'h78, 8'h00);
    rd(8'h77, d);
    chk(d > 8'h00 && d < 8'h10, 1);
    lrange = 10'h3e8;
    wr(8'h65, 8'h80);
    tk(2);
    chk(aux_src, 4'h3);
    chk(lre, 10'h3e8);
    wr(8'h65, 8'h00);
    tk(2);
    chk(aux_src, 4'h9);
  endtask
  // Automatic build-out on a jump
  task automatic t_pbo();
    pd = 200;
    tk();
    pd = 1200;
    wait_ev(10);
    chk(pev, 1);
    wait_hold();
    chk(corr.offset_ns, 1200);
  endtask
  // Manual flag, quiet expiry, freeze
  task automatic t_quiet();
    ctrl.auto_hi = 0;
    pd = 1400;
    tk();
    pd = 2700;
    for (n = 0; n < 10 && jflag !== 1'b1; n++) tk();
    chk(jflag, 1);
    pd = 1200;
    tk(300);
    ctrl.auto_hi = 1;
    pd = 1400;
    for (i = 0; i < 400; i++) begin
      tk();
      if (pev !== 1'b0 || jflag !== 1'b0) chk(pev, 2);
    end
    ctrl.freeze = 1;
    pd = 2700;
    ref_switch = 1;
    tk();
    ref_switch = 0;
    for (i = 0; i < 300; i++) begin
      tk();
      if (pev !== 1'b0) chk(pev, 0);
    end
    chk(corr.offset_ns, 1200);
    pd = 1200;
    ctrl.freeze = 0;
    tk(300);
  endtask
  // Disable slews back, enable while locked fires
  task automatic t_dis();
    ctrl = '{1'b0, 1'b0, 1'b0, 1'b0, 12'h3e8, 4'h0};
    tk(1028);
    chk(corr.offset_ns <= 1197 && corr.offset_ns >= 1195, 1);
    chk(corr.fine_adjust_en, 1);
    chk(corr.trim_steps, 8'h00);
    ctrl = '{1'b1, 1'b0, 1'b1, 1'b1, 12'h3e8, 4'h0};
    wait_ev(5);
    chk(pev, 1);
    wait_hold();
    chk(corr.offset_ns, 1200);
    lock = 0;
    ctrl.enable = 0;
    tk(300);
    chk(corr.offset_ns, 1200);
    ctrl.enable = 1;
    for (i = 0; i < 20; i++) begin
      tk();
      if (pev !== 1'b0) chk(pev, 0);
    end
    hreq = 1;
    tk();
    hreq = 0;
    chk(pev, 1);
    lock = 1;
    wait_hold();
    chk(corr.offset_ns, 1200);
  endtask
  // Reference monitors
  task automatic t_ref();
    logic [7:0] d;
    chk(usable, 14'h3fff);
    chk(frs, 0);
    rc(8'h4b, 8'h00);
    rd(8'h4c, d);
    chk(d <= 8'h01, 1);
    run[3] = 0;
    jit[5] = 1;
    for (n = 0; n < 5000 && usable[3] !== 1'b0; n++) tk();
    chk(usable[3], 0);
    for (n = 0; n < 5000 && usable[5] !== 1'b0; n++) tk();
    chk(usable[5], 0);
    sref = 4'h3;
    tk(2);
    chk(frs, 1);
    run[3] = 1;
    for (n = 0; n < 9000 && usable[3] !== 1'b1; n++) tk();
    chk(usable[3], 1);
    chk(frs, 0);
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1;
    tk(2);
    t_reg();
    t_pbo();
    t_quiet();
    t_dis();
    t_ref();
    wrap_up();
  end
endmodule
`default_nettype wire
